// ### verilog/adccfg_pkg.sv
package adccfg_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_HOLD = 8'h13;
  localparam logic [7:0] ADDR_IFPWR = 8'h14;
  localparam logic [7:0] ADDR_PAT = 8'h16;
  localparam logic [7:0] ADDR_GAIN = 8'h17;
  localparam logic [7:0] ADDR_CUSTLO = 8'h18;
  localparam logic [7:0] ADDR_CUSTHI = 8'h19;
  localparam logic [7:0] ADDR_TRIM = 8'h1a;
  localparam logic [7:0] ADDR_FIR = 8'h1b;
  localparam logic [7:0] ADDR_BAND = 8'h1d;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int FREEZE_BIT = 4;
  localparam int COARSE_BIT = 4;
  localparam int IFSEL_BIT = 5;
  localparam int OVRD_BIT = 7;
  localparam int REF_BIT = 3;
  localparam int BYTEWISE_BIT = 3;
  localparam int FORMAT_BIT = 4;
  localparam int LOWLAT_BIT = 7;
  localparam int ODDTAP_BIT = 3;
  localparam int FILTEN_BIT = 4;
  localparam int COEFSEL_BIT = 5;
  localparam int OFFEN_BIT = 7;
  // ----------------------------------------
  // reset values and widths
  // ----------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int WORD_BITS = 16;
  localparam int SAMPLE_BITS = 14;
  localparam int LOWLAT_CYCLES = 10;
  localparam logic [3:0] GAIN_MAX = 4'hc;
  localparam logic [3:0] CORR_MAX = 4'ha;
  // ----------------------------------------
  // mode codes
  // ----------------------------------------
  localparam logic [2:0] PWR_MUX = 3'h7;
  localparam logic [2:0] PAT_CUSTOM = 3'h5;
  typedef enum logic [1:0] {ADCCFG_DEC2, ADCCFG_DEC4, ADCCFG_DEC8, ADCCFG_DEC1} adccfg_dec_e;
endpackage : adccfg_pkg

// ### verilog/adccfg_serial_rx.sv
// serial word receiver: pins synchronised, falling clock edges sampled
module adccfg_serial_rx
  import adccfg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial pins
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic serial_select_n,
  // received word
  output logic word_valid,
  output logic [7:0] word_addr,
  output logic [7:0] word_data
);
  logic [2:0] sclk_s;
  logic [1:0] sdat_s;
  logic [1:0] sen_s;
  logic [15:0] shift;
  logic [4:0] count;
  logic fall;

  // ---------------------------------------
  // two-flop synchronisers, third stage for edges
  // ---------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_s <= 3'h0;
      sdat_s <= 2'h0;
      sen_s <= 2'h3;
    end else begin
      sclk_s <= {sclk_s[1:0], serial_clk};
      sdat_s <= {sdat_s[0], serial_data};
      sen_s <= {sen_s[0], serial_select_n};
    end
  end

  assign fall = sclk_s[2] & ~sclk_s[1];

  // shift in on falling edges; partial words dropped when select rises
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift <= 16'h0000;
      count <= 5'h00;
      word_valid <= 1'b0;
    end else begin
      word_valid <= 1'b0;
      if (sen_s[1]) begin
        count <= 5'h00; // RULE2
      end else if (fall) begin
        shift <= {shift[14:0], sdat_s[1]}; // RULE2
        if (count == 5'(WORD_BITS - 1)) begin
          count <= 5'h00;
          word_valid <= 1'b1; // RULE2
        end else begin
          count <= count + 5'h01;
        end
      end
    end
  end

  // address first, data last
  assign word_addr = shift[15:8]; // RULE1
  assign word_data = shift[7:0]; // RULE1
endmodule : adccfg_serial_rx

// ### verilog/adccfg_dc_loop.sv
// offset estimator: running estimate with selectable time constant and freeze
module adccfg_dc_loop
  import adccfg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // controls
  input wire logic sample_en,
  input wire logic freeze,
  input wire logic [4:0] tc_shift,
  // sample in, estimate out
  input wire logic signed [13:0] sample_in,
  output logic signed [13:0] estimate
);
  logic signed [47:0] acc;

  // leaky integrator; acc holds estimate scaled by 2^tc_shift
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc <= 48'sh0;
    end else if (sample_en && !freeze) begin // RULE3
      acc <= acc + 48'(sample_in) - (acc >>> tc_shift);
    end
  end

  // frozen estimate keeps cancelling
  assign estimate = 14'(acc >>> tc_shift); // RULE3
endmodule : adccfg_dc_loop

// ### verilog/adccfg_regs.sv
// ----------------------------------------
// configuration register bank
// ----------------------------------------
// Summary of operation
// RULE1: each write is 16 bits, address byte first then data byte.
// RULE2: sample data on falling clock, commit at 16th edge, drop short tails.
// RULE3: freeze bit stops offset estimate updates, last estimate keeps cancelling.
// RULE4: power field decodes normal, buffer disables, global down, standby.
// RULE5: power code 111 interleaves both channels onto B pins, CMOS only.
// RULE6: coarse gain bit selects 0 dB or 3.5 dB.
// RULE7: interface bit selects parallel CMOS or DDR LVDS.
// RULE8: override bit lets register fields beat the control pins.
// RULE9: pattern field selects samples, zeros, ones, toggle, ramp, custom.
// RULE10: custom pattern is 14 bits from two registers.
// RULE11: bit-wise DDR sends odd bits rising, even bits falling.
// RULE12: byte-wise DDR sends lower bits rising, upper bits falling.
// RULE13: format bit picks two's complement or offset binary.
// RULE14: gain field in 0.5 dB steps, codes up to 1100.
// RULE15: fine correction in 0.05 dB steps up to 1010, both channels.
// RULE16: loop time-constant field maps to power-of-two sample counts.
// RULE17: low-latency bit bypasses processing, 10 cycle latency.
// RULE18: decimation field selects by 2, 4, none or 8.
// RULE19: odd-tap bit selects 23 instead of 24 coefficients.
// RULE20: filter enable bit and coefficient source bit.
// RULE21: decimate-by-2 band code selects low-pass or high-pass.
// RULE22: decimate-by-4 band code selects low-pass or band-pass.
// RULE23: offset enable bit gates offset correction; reserved bits read zero.
module adccfg_regs
  import adccfg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial write pins
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic serial_select_n,
  // parallel control pins
  input wire logic pin_lvds_sel,
  input wire logic [2:0] pin_pwr_mode,
  // converter samples
  input wire logic sample_en,
  input wire logic [13:0] sample_a,
  input wire logic [13:0] sample_b,
  // decoded mode outputs
  output logic lvds_mode,
  output logic out_buf_a_en,
  output logic out_buf_b_en,
  output logic global_pdn,
  output logic standby_a,
  output logic standby_b,
  output logic mux_mode,
  output logic coarse_gain_on,
  output logic ext_ref,
  output logic [3:0] fine_gain,
  output logic [3:0] gain_corr,
  output logic [4:0] dc_loop_time_constant,
  output logic low_latency,
  output logic [3:0] proc_latency,
  output logic [1:0] decim_mode,
  output logic decim_valid,
  output logic odd_taps,
  output logic [4:0] coef_count,
  output logic filter_en,
  output logic user_coefs,
  output logic [1:0] band_shape_select,
  output logic band_highpass,
  output logic band_bandpass,
  output logic offset_corr_en,
  // formatted outputs
  output logic [13:0] data_a,
  output logic [13:0] data_b,
  output logic [6:0] ddr_rise_a,
  output logic [6:0] ddr_fall_a,
  output logic [6:0] ddr_rise_b,
  output logic [6:0] ddr_fall_b,
  output logic second_channel_msb_pin
);
  logic [7:0] dc_estimate_hold_ctrl;
  logic [7:0] interface_gain_power_ctrl;
  logic [7:0] output_pattern_format_ctrl;
  logic [7:0] programmable_gain_ctrl;
  logic [7:0] user_pattern_lower;
  logic [7:0] user_pattern_upper;
  logic [7:0] latency_trim_loop_ctrl;
  logic [7:0] fir_decimation_ctrl;
  logic [7:0] band_shape_ctrl;
  logic word_valid;
  logic [7:0] word_addr;
  logic [7:0] word_data;
  logic [2:0] pin_pwr_s1, pin_pwr_s2;
  logic pin_lvds_s1, pin_lvds_s2;
  logic [2:0] pwr_code;
  logic [13:0] ramp;
  logic toggle;
  logic mux_phase;
  logic [13:0] pat_a, pat_b;
  logic [13:0] fmt_a, fmt_b;
  logic signed [13:0] est_a, est_b;
  logic [13:0] corr_a, corr_b;
  logic [13:0] mux_word;

  // ---------------------------------------
  // serial receiver
  // ---------------------------------------
  adccfg_serial_rx u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .serial_clk(serial_clk),
    .serial_data(serial_data),
    .serial_select_n(serial_select_n),
    .word_valid(word_valid),
    .word_addr(word_addr),
    .word_data(word_data)
  );

  // ---------------------------------------
  // register writes, reserved bits held at zero
  // ---------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dc_estimate_hold_ctrl <= REG_RESET;
      interface_gain_power_ctrl <= REG_RESET;
      output_pattern_format_ctrl <= REG_RESET;
      programmable_gain_ctrl <= REG_RESET;
      user_pattern_lower <= REG_RESET;
      user_pattern_upper <= REG_RESET;
      latency_trim_loop_ctrl <= REG_RESET;
      fir_decimation_ctrl <= REG_RESET;
      band_shape_ctrl <= REG_RESET;
    end else if (word_valid) begin // RULE2
      unique case (word_addr)
        ADDR_HOLD: dc_estimate_hold_ctrl <= word_data & 8'h10; // RULE23
        ADDR_IFPWR: interface_gain_power_ctrl <= word_data & 8'hbf;
        ADDR_PAT: output_pattern_format_ctrl <= word_data & 8'h1f;
        ADDR_GAIN: programmable_gain_ctrl <= word_data & 8'h0f;
        ADDR_CUSTLO: user_pattern_lower <= word_data;
        ADDR_CUSTHI: user_pattern_upper <= word_data & 8'h3f;
        ADDR_TRIM: latency_trim_loop_ctrl <= word_data & 8'hff;
        ADDR_FIR: fir_decimation_ctrl <= word_data & 8'hbf;
        ADDR_BAND: band_shape_ctrl <= word_data & 8'h03;
        default: ; // other addresses ignored
      endcase
    end
  end

  // ---------------------------------------
  // parallel pin synchronisers
  // ---------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_pwr_s1 <= 3'h0;
      pin_pwr_s2 <= 3'h0;
      pin_lvds_s1 <= 1'b0;
      pin_lvds_s2 <= 1'b0;
    end else begin
      pin_pwr_s1 <= pin_pwr_mode;
      pin_pwr_s2 <= pin_pwr_s1;
      pin_lvds_s1 <= pin_lvds_sel;
      pin_lvds_s2 <= pin_lvds_s1;
    end
  end

  // ---------------------------------------
  // interface and power decode
  // ---------------------------------------
  always_comb begin
    if (interface_gain_power_ctrl[OVRD_BIT]) begin // RULE8
      pwr_code = interface_gain_power_ctrl[2:0];
      lvds_mode = interface_gain_power_ctrl[IFSEL_BIT]; // RULE7
    end else begin
      pwr_code = pin_pwr_s2;
      lvds_mode = pin_lvds_s2;
    end
  end

  // power-state decode
  assign out_buf_a_en = !(pwr_code == 3'h1 || pwr_code == 3'h3); // RULE4
  assign out_buf_b_en = !(pwr_code == 3'h2 || pwr_code == 3'h3); // RULE4
  assign global_pdn = (pwr_code == 3'h4); // RULE4
  assign standby_a = (pwr_code == 3'h5); // RULE4
  assign standby_b = (pwr_code == 3'h6); // RULE4
  assign mux_mode = (pwr_code == PWR_MUX) && !lvds_mode; // RULE5
  assign coarse_gain_on = interface_gain_power_ctrl[COARSE_BIT]; // RULE6
  assign ext_ref = interface_gain_power_ctrl[REF_BIT];

  // ---------------------------------------
  // gain and trim fields
  // ---------------------------------------
  // unused codes saturate at the top step
  assign fine_gain = (programmable_gain_ctrl[3:0] > GAIN_MAX) ? GAIN_MAX :
                     programmable_gain_ctrl[3:0]; // RULE14
  assign gain_corr = (latency_trim_loop_ctrl[3:0] > CORR_MAX) ? CORR_MAX :
                     latency_trim_loop_ctrl[3:0]; // RULE15
  assign low_latency = latency_trim_loop_ctrl[LOWLAT_BIT];
  assign proc_latency = low_latency ? 4'(LOWLAT_CYCLES) : 4'h0; // RULE17

  // time constant as a power of two
  always_comb begin
    unique case (latency_trim_loop_ctrl[6:4]) // RULE16
      3'h1: dc_loop_time_constant = 5'd26;
      3'h2: dc_loop_time_constant = 5'd25;
      3'h3: dc_loop_time_constant = 5'd24;
      3'h4: dc_loop_time_constant = 5'd28;
      3'h5: dc_loop_time_constant = 5'd29;
      default: dc_loop_time_constant = 5'd27;
    endcase
  end

  // ---------------------------------------
  // filter controls
  // ---------------------------------------
  always_comb begin
    decim_valid = 1'b1;
    unique case (fir_decimation_ctrl[2:0]) // RULE18
      3'h0: decim_mode = 2'(ADCCFG_DEC2);
      3'h1: decim_mode = 2'(ADCCFG_DEC4);
      3'h3: decim_mode = 2'(ADCCFG_DEC1);
      3'h4: decim_mode = 2'(ADCCFG_DEC8);
      default: begin
        decim_mode = 2'(ADCCFG_DEC2);
        decim_valid = 1'b0;
      end
    endcase
    // built-in set only serves by-2 and by-4
    if (!fir_decimation_ctrl[COEFSEL_BIT] && decim_mode[1]) begin
      decim_valid = 1'b0; // RULE18
    end
  end

  assign odd_taps = fir_decimation_ctrl[ODDTAP_BIT];
  assign coef_count = odd_taps ? 5'd23 : 5'd24; // RULE19
  assign filter_en = fir_decimation_ctrl[FILTEN_BIT] && !low_latency; // RULE20
  assign user_coefs = fir_decimation_ctrl[COEFSEL_BIT]; // RULE20
  assign offset_corr_en = fir_decimation_ctrl[OFFEN_BIT] && !low_latency; // RULE23
  assign band_shape_select = band_shape_ctrl[1:0];
  assign band_highpass = (decim_mode == 2'(ADCCFG_DEC2)) &&
                         (band_shape_select == 2'h1); // RULE21
  assign band_bandpass = (decim_mode == 2'(ADCCFG_DEC4)) &&
                         (band_shape_select == 2'h1); // RULE22

  // ---------------------------------------
  // offset loops
  // ---------------------------------------
  // loops see samples as signed: msb flipped so midscale reads as zero
  adccfg_dc_loop u_dc_a (
    .clk(clk),
    .rst_n(rst_n),
    .sample_en(sample_en),
    .freeze(dc_estimate_hold_ctrl[FREEZE_BIT]),
    .tc_shift(dc_loop_time_constant),
    .sample_in(signed'({~sample_a[13], sample_a[12:0]})),
    .estimate(est_a)
  );
  adccfg_dc_loop u_dc_b (
    .clk(clk),
    .rst_n(rst_n),
    .sample_en(sample_en),
    .freeze(dc_estimate_hold_ctrl[FREEZE_BIT]),
    .tc_shift(dc_loop_time_constant),
    .sample_in(signed'({~sample_b[13], sample_b[12:0]})),
    .estimate(est_b)
  );

  assign corr_a = offset_corr_en ? 14'(sample_a - est_a) : sample_a; // RULE3
  assign corr_b = offset_corr_en ? 14'(sample_b - est_b) : sample_b; // RULE3

  // ---------------------------------------
  // test pattern generators
  // ---------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ramp <= 14'h0000;
      toggle <= 1'b0;
      mux_phase <= 1'b0;
    end else if (sample_en) begin
      ramp <= ramp + 14'h0001;
      toggle <= ~toggle;
      mux_phase <= ~mux_phase;
    end
  end

  // pattern selection for one channel
  function automatic logic [13:0] pick(input logic [2:0] code, input logic [13:0] smp,
                                       input logic [13:0] rmp, input logic tg,
                                       input logic [13:0] cust);
    unique case (code) // RULE9
      3'h1: pick = 14'h0000;
      3'h2: pick = 14'h3fff;
      3'h3: pick = tg ? 14'h2aaa : 14'h1555;
      3'h4: pick = rmp;
      PAT_CUSTOM: pick = cust; // RULE10
      default: pick = smp; // normal, and unused codes
    endcase
  endfunction : pick

  // offset binary to two's complement flips the msb
  function automatic logic [13:0] fmt(input logic twos, input logic [13:0] w);
    fmt = twos ? {~w[13], w[12:0]} : w;
  endfunction : fmt

  assign pat_a = pick(output_pattern_format_ctrl[2:0], corr_a, ramp, toggle,
                      {user_pattern_upper[5:0], user_pattern_lower}); // RULE10
  assign pat_b = pick(output_pattern_format_ctrl[2:0], corr_b, ramp, toggle,
                      {user_pattern_upper[5:0], user_pattern_lower});
  // samples arrive in offset binary
  assign fmt_a = fmt(output_pattern_format_ctrl[FORMAT_BIT], pat_a); // RULE13
  assign fmt_b = fmt(output_pattern_format_ctrl[FORMAT_BIT], pat_b); // RULE13
  assign mux_word = mux_phase ? fmt_b : fmt_a; // RULE5

  // ---------------------------------------
  // output registers and DDR split
  // ---------------------------------------
  function automatic logic [13:0] ddr_split(input logic bytewise, input logic [13:0] w);
    logic [6:0] odd_b;
    logic [6:0] even_b;
    odd_b = 7'h00;
    even_b = 7'h00;
    for (int i = 0; i < 7; i++) begin
      odd_b[i] = w[2 * i + 1];
      even_b[i] = w[2 * i];
    end
    // returns {falling half, rising half}
    ddr_split = bytewise ? w : {even_b, odd_b}; // RULE11 RULE12
  endfunction : ddr_split

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_a <= 14'h0000;
      data_b <= 14'h0000;
      {ddr_fall_a, ddr_rise_a} <= 14'h0000;
      {ddr_fall_b, ddr_rise_b} <= 14'h0000;
    end else if (sample_en) begin
      data_a <= (out_buf_a_en && !mux_mode) ? fmt_a : 14'h0000;
      data_b <= !out_buf_b_en ? 14'h0000 : (mux_mode ? mux_word : fmt_b); // RULE5
      {ddr_fall_a, ddr_rise_a} <= ddr_split(output_pattern_format_ctrl[BYTEWISE_BIT], fmt_a);
      {ddr_fall_b, ddr_rise_b} <= ddr_split(output_pattern_format_ctrl[BYTEWISE_BIT], fmt_b);
    end
  end

  assign second_channel_msb_pin = data_b[SAMPLE_BITS - 1];
endmodule : adccfg_regs

// ### sim/adccfg_regs_asserts.sv
// ----------------------------------------
// port checker for the register bank
// ----------------------------------------
module adccfg_regs_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched inputs
  input wire logic serial_select_n,
  input wire logic sample_en,
  // watched mode outputs
  input wire logic lvds_mode,
  input wire logic global_pdn,
  input wire logic standby_a,
  input wire logic standby_b,
  input wire logic mux_mode,
  input wire logic [3:0] fine_gain,
  input wire logic [3:0] gain_corr,
  input wire logic low_latency,
  input wire logic [3:0] proc_latency,
  input wire logic [1:0] decim_mode,
  input wire logic odd_taps,
  input wire logic [4:0] coef_count,
  input wire logic filter_en,
  input wire logic band_highpass,
  input wire logic band_bandpass,
  // watched data outputs
  input wire logic [13:0] data_a,
  input wire logic [13:0] data_b
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_MUX_CMOS: assert property (mux_mode |-> !lvds_mode && !global_pdn)
    else $error("mux mode with lvds or power down");
  AST_PWR_ONEHOT: assert property ($onehot0({global_pdn, standby_a, standby_b, mux_mode}))
    else $error("power states overlap");
  AST_LAT_FIGURE: assert property (proc_latency == (low_latency ? 4'ha : 4'h0))
    else $error("latency figure wrong");
  AST_LAT_BYPASS: assert property (low_latency |-> !filter_en)
    else $error("filter on in bypass");
  AST_TAP_COUNT: assert property (coef_count == (odd_taps ? 5'h17 : 5'h18))
    else $error("coefficient count wrong");
  AST_GAIN_CEIL: assert property (fine_gain <= 4'hc)
    else $error("gain above top code");
  AST_CORR_CEIL: assert property (gain_corr <= 4'ha)
    else $error("correction above top code");
  AST_HP_DEC2: assert property (band_highpass |-> decim_mode == 2'h0)
    else $error("high pass outside by-2");
  AST_BP_DEC4: assert property (band_bandpass |-> decim_mode == 2'h1)
    else $error("band pass outside by-4");
  AST_QUIET_SELECT: assert property (serial_select_n [*8] |=> $stable({fine_gain, gain_corr}))
    else $error("register moved without a frame");
  AST_DATA_HOLD: assert property (!sample_en |=> $stable({data_a, data_b}))
    else $error("data moved without a sample");
endmodule : adccfg_regs_asserts

// ### sim/adccfg_ser_host.sv
// ----------------------------------------
// serial write controller model
// ----------------------------------------
module adccfg_ser_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request from the bench
  input wire logic req,
  input wire logic [31:0] word,
  input wire logic [5:0] nbits,
  output logic busy,
  // serial pins
  output logic serial_clk,
  output logic serial_data,
  output logic serial_select_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] sh;
  logic [5:0] left;
  logic [2:0] ph;
  // msb first, address byte then data byte; clock idles low, 4 clk per half
  always @(posedge clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      serial_clk <= 1'b0;
      serial_data <= 1'b0;
      serial_select_n <= 1'b1;
      ph <= 3'h0;
    end else if (!busy) begin
      if (req) begin
        busy <= 1'b1;
        sh <= word;
        left <= nbits;
        ph <= 3'h0;
        serial_select_n <= 1'b0;
      end
    end else begin
      ph <= ph + 3'h1;
      if (left == 6'h0) begin
        serial_data <= 1'b0; // released line sits at its pull-down
        if (ph == 3'h3) begin
          serial_select_n <= 1'b1;
          busy <= 1'b0;
        end
      end else if (ph == 3'h3) begin
        serial_data <= sh[31];
        serial_clk <= 1'b1;
      end else if (ph == 3'h7) begin
        serial_clk <= 1'b0;
        sh <= {sh[30:0], 1'b0};
        left <= left - 6'h1;
      end
    end
  end
endmodule : adccfg_ser_host

// ### sim/adccfg_regs_bench.sv
module adccfg_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import adccfg_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic [31:0] word = 32'h0;
  logic [5:0] nbits = 6'h10;
  logic pin_lvds_sel = 1'b0;
  logic [2:0] pin_pwr_mode = 3'h0;
  logic sample_en = 1'b0;
  logic [13:0] sample_a = 14'h0;
  logic [13:0] sample_b = 14'h0;
  logic busy, serial_clk, serial_data, serial_select_n;
  logic lvds_mode, out_buf_a_en, out_buf_b_en, global_pdn, standby_a, standby_b, mux_mode;
  logic coarse_gain_on, ext_ref, low_latency, decim_valid, odd_taps, filter_en, user_coefs;
  logic band_highpass, band_bandpass, offset_corr_en, second_channel_msb_pin;
  logic [3:0] fine_gain, gain_corr, proc_latency;
  logic [4:0] dc_loop_time_constant, coef_count;
  logic [1:0] decim_mode, band_shape_select;
  logic [13:0] data_a, data_b, prev;
  logic [6:0] ddr_rise_a, ddr_fall_a, ddr_rise_b, ddr_fall_b;
  logic [4:0] tcx [7] = '{5'h1b, 5'h1a, 5'h19, 5'h18, 5'h1c, 5'h1d, 5'h1b};
  logic [13:0] pexp [6] = '{14'h0, 14'h0, 14'h3fff, 14'h3fff, 14'h1, 14'h3ca5};
  int bad_count = 0;
  int n_compared = 0;
  // 50 ns clock
  always #25 clk = ~clk;
  adccfg_ser_host i_adccfg_ser_host (.clk, .rst_n, .req, .word, .nbits, .busy, .serial_clk,
    .serial_data, .serial_select_n);
  adccfg_regs i_adccfg_regs (.clk, .rst_n, .serial_clk, .serial_data, .serial_select_n,
    .pin_lvds_sel, .pin_pwr_mode, .sample_en, .sample_a, .sample_b, .lvds_mode, .out_buf_a_en,
    .out_buf_b_en, .global_pdn, .standby_a, .standby_b, .mux_mode, .coarse_gain_on, .ext_ref,
    .fine_gain, .gain_corr, .dc_loop_time_constant, .low_latency, .proc_latency, .decim_mode,
    .decim_valid, .odd_taps, .coef_count, .filter_en, .user_coefs, .band_shape_select,
    .band_highpass, .band_bandpass, .offset_corr_en, .data_a, .data_b, .ddr_rise_a, .ddr_fall_a,
    .ddr_rise_b, .ddr_fall_b, .second_channel_msb_pin);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done;
    if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one framed transfer, then room for the commit
  task automatic send(input logic [31:0] w, input logic [5:0] n);
    int k;
    @(negedge clk);
    word = w;
    nbits = n;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    k = 0;
    while (busy !== 1'b0 && k < 1000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 1000) begin
      bad_count++;
      test_done();
    end
    repeat (8) @(negedge clk);
  endtask : send
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    send({a, d, 16'h0}, 6'h10);
  endtask : wr
  task automatic smp(input logic [13:0] a, input logic [13:0] b);
    @(negedge clk);
    sample_a = a;
    sample_b = b;
    sample_en = 1'b1;
    @(negedge clk);
    sample_en = 1'b0;
    repeat (2) @(negedge clk);
  endtask : smp
  function automatic logic [6:0] pick(input logic [13:0] v, input int s);
    for (int i = 0; i < 7; i++) pick[i] = v[2 * i + s];
  endfunction : pick
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk({out_buf_a_en, out_buf_b_en, decim_valid, filter_en}, 4'he);
    chk({fine_gain, gain_corr}, 8'h00);
    chk(dc_loop_time_constant, 5'h1b);
    chk(coef_count, 5'h18);
  endtask : t_reset
  task automatic t_power;
    pin_pwr_mode = 3'h4;
    pin_lvds_sel = 1'b1;
    repeat (6) @(negedge clk);
    chk({global_pdn, lvds_mode}, 2'h3);
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_IFPWR, 8'h80 | 8'(c));
      chk({global_pdn, standby_a, standby_b, mux_mode, lvds_mode},
        (c < 4) ? 5'h0 : 5'(5'h10 >> (c - 4)));
      if (c < 4) chk({out_buf_a_en, out_buf_b_en}, {!c[0], !c[1]});
    end
    pin_pwr_mode = 3'h0;
    pin_lvds_sel = 1'b0;
    wr(ADDR_IFPWR, 8'hb8);
    chk({lvds_mode, coarse_gain_on, ext_ref, global_pdn}, 4'he);
  endtask : t_power
  task automatic t_gain;
    for (int g = 0; g < 16; g++) begin
      wr(ADDR_GAIN, 8'(g));
      wr(ADDR_TRIM, {1'b0, 3'(g), 4'(g)});
      chk(fine_gain, (g > 12) ? 16'hc : 16'(g));
      chk(gain_corr, (g > 10) ? 16'ha : 16'(g));
      if (g % 8 != 7) chk(dc_loop_time_constant, tcx[g % 8]);
    end
    wr(ADDR_TRIM, 8'h80);
    chk({low_latency, proc_latency}, 5'h1a);
    wr(ADDR_TRIM, 8'h00);
    wr(ADDR_GAIN, 8'h00);
  endtask : t_gain
  task automatic t_fir;
    wr(ADDR_FIR, 8'h90);
    wr(ADDR_BAND, 8'h01);
    chk({decim_mode, decim_valid, filter_en, user_coefs, offset_corr_en}, 6'h0d);
    chk({coef_count, band_highpass, band_bandpass, band_shape_select}, {5'h18, 4'h9});
    wr(ADDR_FIR, 8'h39);
    chk({decim_mode, odd_taps, coef_count, user_coefs, offset_corr_en}, {3'h3, 5'h17, 2'h2});
    chk({band_bandpass, band_highpass}, 2'h2);
    wr(ADDR_FIR, 8'h23);
    chk({decim_mode, decim_valid}, 3'h7);
    wr(ADDR_FIR, 8'h24);
    chk({decim_mode, decim_valid}, 3'h5);
    wr(ADDR_FIR, 8'h04);
    chk(decim_valid, 1'b0);
    wr(ADDR_FIR, 8'h00);
    wr(ADDR_BAND, 8'h00);
  endtask : t_fir
  task automatic t_patterns;
    wr(ADDR_CUSTLO, 8'ha5);
    wr(ADDR_CUSTHI, 8'h3c);
    wr(ADDR_PAT, 8'h00);
    smp(14'h2345, 14'h1c3a);
    chk(data_a, 14'h2345);
    chk({ddr_rise_b, ddr_fall_b}, {pick(14'h1c3a, 1), pick(14'h1c3a, 0)});
    wr(ADDR_PAT, 8'h18);
    smp(14'h2345, 14'h1c3a);
    chk(data_a, 14'h0345);
    chk({ddr_rise_b, ddr_fall_b}, {7'h3a, 7'h78});
    chk({ddr_rise_a, ddr_fall_a, second_channel_msb_pin}, {7'h45, 7'h06, 1'b1});
    for (int c = 1; c < 6; c++) begin
      wr(ADDR_PAT, 8'(c));
      smp(14'h2345, 14'h1c3a);
      prev = data_a;
      smp(14'h2345, 14'h1c3a);
      chk((c == 3) ? data_a ^ prev : (c == 4) ? data_a - prev : data_a, pexp[c]);
    end
    wr(ADDR_PAT, 8'h00);
    // mux mode: twelve samples so far, so channel A comes first on the B pins
    wr(ADDR_IFPWR, 8'h87);
    smp(14'h2345, 14'h1c3a);
    chk(data_b, 14'h2345);
    smp(14'h2345, 14'h1c3a);
    chk(data_b, 14'h1c3a);
    chk(data_a, 14'h0000);
    wr(ADDR_IFPWR, 8'hb8);
  endtask : t_patterns
  task automatic t_framing;
    send({8'h17, 8'h05, 16'h0}, 6'h0c);
    chk(fine_gain, 4'h0);
    send({8'h17, 8'h03, 16'hf000}, 6'h14);
    chk(fine_gain, 4'h3);
    send({8'h17, 8'h06, 8'h1a, 8'h02}, 6'h20);
    chk({fine_gain, gain_corr}, 8'h62);
    wr(8'h15, 8'hff);
    chk({fine_gain, gain_corr, lvds_mode}, 9'hc5);
  endtask : t_framing
  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_power();
    t_gain();
    t_fir();
    t_patterns();
    t_framing();
    test_done();
  end
endmodule : adccfg_regs_bench
bind adccfg_regs adccfg_regs_asserts i_adccfg_regs_asserts (.clk, .rst_n, .serial_select_n,
  .sample_en, .lvds_mode, .global_pdn, .standby_a, .standby_b, .mux_mode, .fine_gain,
  .gain_corr, .low_latency, .proc_latency, .decim_mode, .odd_taps, .coef_count, .filter_en,
  .band_highpass, .band_bandpass, .data_a, .data_b);
